// [ppd_port_top.sv]
// general-purpose port block: apb registers, second-function routing
`timescale 1ns/1ps
//
// Summary of operation
// - 66 pins, each bit's direction set separately
// - direction bit 1 output, 0 input
// - reset clears every direction bit to input
// - output pin reads back its latch value
// - write to input pin only updates latch
// - active second function decides pin direction
// - expanded modes: address ports carry address bus
// - expanded modes: control port bits 0,3-7 bus control
// - input pin reads its sensed level
// - data-bus port is external data in expanded modes
// - master data port serves master when enabled
// - port 5 bits 2,3 drive buffer-full flags
// - port 7 bit 0 outputs frame pulse when enabled
module ppd_port_top
    import ppd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ppd_pkg::NPINS-1:0] pin_in,
    output logic [ppd_pkg::NPINS-1:0] pin_out,
    output logic [ppd_pkg::NPINS-1:0] pin_oe_n,
    output logic [1:0] proc_mode,
    input wire logic [15:0] external_address_lines,
    input wire logic [7:0] bus_ctrl_out,
    input wire logic [7:0] bus_ctrl_drive,
    input wire logic [7:0] ext_data_out,
    input wire logic ext_data_drive,
    input wire logic [7:0] master_data_out,
    input wire logic master_data_drive,
    input wire logic output_buffer_full_flag0,
    input wire logic input_buffer_full_flag0,
    input wire logic frame_pulse,
    input wire logic [ppd_pkg::NPINS-1:0] alt_en,
    input wire logic [ppd_pkg::NPINS-1:0] alt_dir,
    input wire logic [ppd_pkg::NPINS-1:0] alt_out
);
    ppd_state_t st_r;
    ppd_state_t st_nxt;
    ppd_pin_if pins();
    logic ext_mode;
    logic mapped;
    logic [ADDR_W-1:0] addr;

    function automatic logic is_expanded(input logic [1:0] m);
        return m == MODE_MEM_EXPANSION || m == MODE_MICROPROCESSOR;
    endfunction

    // port number addressed, or NPORTS when the word is not a port register
    function automatic int port_of(input logic [ADDR_W-1:0] a);
        int r;
        r = NPORTS;
        for (int p = 0; p < NPORTS; p++) begin
            if ((a & ~DIR_OFFSET) == ADDR_W'(p * PORT_STRIDE)) begin
                r = p;
            end
        end
        return r;
    endfunction

    // pin index of bit b of port p
    function automatic int pin_of(input int p, input int b);
        return PORT_BASE[p] + b;
    endfunction

    ppd_pin_mux u_mux (
        .pins(pins.mux)
    );

    assign addr = paddr[ADDR_W-1:0];
    assign ext_mode = is_expanded(st_r.mode);
    assign pins.latch = st_r.latch;
    assign pins.dir = st_r.dir;
    assign pins.pin_in = pin_in;
    assign pin_out = pins.pin_out;
    assign pin_oe_n = pins.pin_oe_n;
    assign proc_mode = st_r.mode;
    assign prdata = st_r.rdata;
    // zero wait state: read data was captured in the setup cycle
    assign pready = 1'b1;
    assign mapped = paddr[1:0] == 2'h0 && paddr[31:ADDR_W] == '0 &&
        (addr == CTRL_ADDR || port_of(addr) < NPORTS);
    assign pslverr = psel && penable && !mapped;

    // second-function routing; later entries win over earlier ones
    always_comb begin
        pins.fn_en = alt_en;
        pins.fn_dir = alt_dir;
        pins.fn_out = alt_out;
        if (ext_mode) begin
            for (int b = 0; b < 8; b++) begin
                pins.fn_en[pin_of(ADDRESS_LOW_PORT, b)] = 1'b1;
                pins.fn_dir[pin_of(ADDRESS_LOW_PORT, b)] = 1'b1;
                pins.fn_out[pin_of(ADDRESS_LOW_PORT, b)] =
                    external_address_lines[b];
                pins.fn_en[pin_of(ADDRESS_HIGH_PORT, b)] = 1'b1;
                pins.fn_dir[pin_of(ADDRESS_HIGH_PORT, b)] = 1'b1;
                pins.fn_out[pin_of(ADDRESS_HIGH_PORT, b)] =
                    external_address_lines[b+8];
                // data bus turns around under the bus controller
                pins.fn_en[pin_of(DATA_BUS_PORT, b)] = 1'b1;
                pins.fn_dir[pin_of(DATA_BUS_PORT, b)] = ext_data_drive;
                pins.fn_out[pin_of(DATA_BUS_PORT, b)] = ext_data_out[b];
                if (BUS_CTRL_MASK[b]) begin
                    pins.fn_en[pin_of(BUS_CONTROL_PORT, b)] = 1'b1;
                    pins.fn_dir[pin_of(BUS_CONTROL_PORT, b)] =
                        bus_ctrl_drive[b];
                    pins.fn_out[pin_of(BUS_CONTROL_PORT, b)] =
                        bus_ctrl_out[b];
                end
            end
        end
        if (st_r.master_bus_enable_bit) begin
            for (int b = 0; b < 8; b++) begin
                pins.fn_en[pin_of(MASTER_DATA_PORT, b)] = 1'b1;
                pins.fn_dir[pin_of(MASTER_DATA_PORT, b)] = master_data_drive;
                pins.fn_out[pin_of(MASTER_DATA_PORT, b)] = master_data_out[b];
            end
            // strobes from the master are inputs only
            for (int b = MASTER_IN_LO_BIT; b <= MASTER_IN_HI_BIT; b++) begin
                pins.fn_en[pin_of(MASTER_CTRL_PORT, b)] = 1'b1;
                pins.fn_dir[pin_of(MASTER_CTRL_PORT, b)] = 1'b0;
                pins.fn_out[pin_of(MASTER_CTRL_PORT, b)] = 1'b0;
            end
        end
        if (st_r.obuf_flag0_pin_enable) begin
            pins.fn_en[pin_of(MASTER_CTRL_PORT, OUTPUT_BUFFER_FULL_FLAG0_BIT)] = 1'b1;
            pins.fn_dir[pin_of(MASTER_CTRL_PORT, OUTPUT_BUFFER_FULL_FLAG0_BIT)] = 1'b1;
            pins.fn_out[pin_of(MASTER_CTRL_PORT, OUTPUT_BUFFER_FULL_FLAG0_BIT)] =
                output_buffer_full_flag0;
        end
        if (st_r.ibuf_flag0_pin_enable) begin
            pins.fn_en[pin_of(MASTER_CTRL_PORT, INPUT_BUFFER_FULL_FLAG0_BIT)] = 1'b1;
            pins.fn_dir[pin_of(MASTER_CTRL_PORT, INPUT_BUFFER_FULL_FLAG0_BIT)] = 1'b1;
            pins.fn_out[pin_of(MASTER_CTRL_PORT, INPUT_BUFFER_FULL_FLAG0_BIT)] =
                input_buffer_full_flag0;
        end
        if (st_r.frame_pulse_out_enable) begin
            pins.fn_en[pin_of(FRAME_PORT, 0)] = 1'b1;
            pins.fn_dir[pin_of(FRAME_PORT, 0)] = 1'b1;
            pins.fn_out[pin_of(FRAME_PORT, 0)] = frame_pulse;
        end
    end

    // register file
    always_comb begin
        int p;
        p = port_of(addr);
        st_nxt = st_r;
        if (psel && !penable) begin
            // capture read data in the setup cycle so prdata is a flop
            st_nxt.rdata = '0;
            if (addr == CTRL_ADDR && mapped) begin
                st_nxt.rdata[CTRL_MODE_LSB +: 2] = st_r.mode;
                st_nxt.rdata[CTRL_MBE_BIT] = st_r.master_bus_enable_bit;
                st_nxt.rdata[CTRL_OBFE_BIT] = st_r.obuf_flag0_pin_enable;
                st_nxt.rdata[CTRL_IBFE_BIT] = st_r.ibuf_flag0_pin_enable;
                st_nxt.rdata[CTRL_SOFE_BIT] = st_r.frame_pulse_out_enable;
            end else if (p < NPORTS && mapped) begin
                for (int b = 0; b < PORT_WIDTH[p]; b++) begin
                    if ((addr & DIR_OFFSET) != '0) begin
                        st_nxt.rdata[b] = st_r.dir[pin_of(p, b)];
                    end else begin
                        st_nxt.rdata[b] = pins.rd_val[pin_of(p, b)];
                    end
                end
            end
        end
        if (psel && penable && pwrite && mapped) begin
            if (addr == CTRL_ADDR) begin
                st_nxt.mode = pwdata[CTRL_MODE_LSB +: 2];
                st_nxt.master_bus_enable_bit = pwdata[CTRL_MBE_BIT];
                st_nxt.obuf_flag0_pin_enable = pwdata[CTRL_OBFE_BIT];
                st_nxt.ibuf_flag0_pin_enable = pwdata[CTRL_IBFE_BIT];
                st_nxt.frame_pulse_out_enable = pwdata[CTRL_SOFE_BIT];
            end else if (p < NPORTS) begin
                // every bit has its own direction and latch
                for (int b = 0; b < PORT_WIDTH[p]; b++) begin
                    if ((addr & DIR_OFFSET) != '0) begin
                        st_nxt.dir[pin_of(p, b)] = pwdata[b];
                    end else begin
                        // latch loads whatever the direction
                        st_nxt.latch[pin_of(p, b)] = pwdata[b];
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.latch <= LATCH_RESET;
            st_r.dir <= DIR_RESET;
            st_r.mode <= MODE_RESET;
            st_r.master_bus_enable_bit <= 1'b0;
            st_r.obuf_flag0_pin_enable <= 1'b0;
            st_r.ibuf_flag0_pin_enable <= 1'b0;
            st_r.frame_pulse_out_enable <= 1'b0;
            st_r.rdata <= 32'h0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// [ppd_pkg.sv]
// constants, register map and state type of the port pin direction mux
package ppd_pkg;
    localparam int NPINS = 66;
    localparam int NPORTS = 9;
    // pin index of bit 0 and width of each port, in port order 0..8
    localparam int PORT_BASE [NPORTS] = '{0, 8, 16, 24, 32, 37, 45, 53, 58};
    localparam int PORT_WIDTH [NPORTS] = '{8, 8, 8, 8, 5, 8, 8, 5, 8};
    // ports named by role
    localparam int ADDRESS_LOW_PORT = 0;
    localparam int ADDRESS_HIGH_PORT = 1;
    localparam int DATA_BUS_PORT = 2;
    localparam int BUS_CONTROL_PORT = 3;
    localparam int MASTER_CTRL_PORT = 5;
    localparam int MASTER_DATA_PORT = 6;
    localparam int FRAME_PORT = 7;
    // port 5 bit positions
    localparam int OUTPUT_BUFFER_FULL_FLAG0_BIT = 2;
    localparam int INPUT_BUFFER_FULL_FLAG0_BIT = 3;
    localparam int MASTER_IN_LO_BIT = 4;
    localparam int MASTER_IN_HI_BIT = 7;
    // bus control port bits taken in expanded modes: 0 and 3..7
    localparam logic [7:0] BUS_CTRL_MASK = 8'hf9;
    // apb map: port k data at k*8, direction at k*8+4, control after them
    localparam logic [7:0] PORT_STRIDE = 8'h08;
    localparam logic [7:0] DIR_OFFSET = 8'h04;
    localparam logic [7:0] CTRL_ADDR = 8'h48;
    localparam int ADDR_W = 8;
    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MBE_BIT = 2;
    localparam int CTRL_OBFE_BIT = 3;
    localparam int CTRL_IBFE_BIT = 4;
    localparam int CTRL_SOFE_BIT = 5;
    // processor modes
    localparam logic [1:0] MODE_SINGLE_CHIP = 2'h0;
    localparam logic [1:0] MODE_MEM_EXPANSION = 2'h1;
    localparam logic [1:0] MODE_MICROPROCESSOR = 2'h2;
    // reset values
    localparam logic [NPINS-1:0] DIR_RESET = 66'h0;
    localparam logic [NPINS-1:0] LATCH_RESET = 66'h0;
    localparam logic [1:0] MODE_RESET = MODE_SINGLE_CHIP;

    typedef struct packed {
        logic [NPINS-1:0] latch;
        logic [NPINS-1:0] dir;
        logic [1:0] mode;
        logic master_bus_enable_bit;
        logic obuf_flag0_pin_enable;
        logic ibuf_flag0_pin_enable;
        logic frame_pulse_out_enable;
        logic [31:0] rdata;
    } ppd_state_t;
endpackage

// [ppd_pin_if.sv]
// per-pin signals between the register core and the pin mux
`timescale 1ns/1ps
interface ppd_pin_if;
    import ppd_pkg::*;
    logic [NPINS-1:0] latch;
    logic [NPINS-1:0] dir;
    logic [NPINS-1:0] fn_en;
    logic [NPINS-1:0] fn_dir;
    logic [NPINS-1:0] fn_out;
    logic [NPINS-1:0] pin_in;
    logic [NPINS-1:0] rd_val;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe_n;
    modport core (output latch, dir, fn_en, fn_dir, fn_out, pin_in,
        input rd_val, pin_out, pin_oe_n);
    modport mux (input latch, dir, fn_en, fn_dir, fn_out, pin_in,
        output rd_val, pin_out, pin_oe_n);
endinterface

// [ppd_pin_mux.sv]
// per-pin direction, driver and read-back mux
`timescale 1ns/1ps
module ppd_pin_mux
    import ppd_pkg::*;
(
    ppd_pin_if.mux pins
);
    logic [NPINS-1:0] eff_dir;

    always_comb begin
        // a second function overrides the direction register
        eff_dir = (pins.fn_en & pins.fn_dir) | (~pins.fn_en & pins.dir);
        // driver on only for outputs; input pins float
        pins.pin_oe_n = ~eff_dir;
        pins.pin_out = (pins.fn_en & pins.fn_out) | (~pins.fn_en & pins.latch);
        // outputs read back the latch, inputs the pin level
        pins.rd_val = (eff_dir & pins.latch) | (~eff_dir & pins.pin_in);
    end
endmodule

// [ppd_port_assertions.sv]
// concurrent checks on the pins and apb side of the port block
`timescale 1ns/1ps
module ppd_port_checker
    import ppd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [ppd_pkg::NPINS-1:0] pin_out,
    input wire logic [ppd_pkg::NPINS-1:0] pin_oe_n,
    input wire logic [1:0] proc_mode,
    input wire logic [15:0] external_address_lines,
    input wire logic [7:0] bus_ctrl_out,
    input wire logic [7:0] bus_ctrl_drive,
    input wire logic ext_data_drive,
    input wire logic frame_pulse,
    input wire logic [ppd_pkg::NPINS-1:0] alt_en,
    input wire logic [ppd_pkg::NPINS-1:0] alt_dir
);
    logic wr;
    logic xm;
    logic [5:0] ctrl_r;
    assign wr = psel && penable && pwrite;
    assign xm = proc_mode == MODE_MEM_EXPANSION
        || proc_mode == MODE_MICROPROCESSOR;
    // enables are not visible at the pins, so keep a shadow of them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 6'h0;
        end else if (wr && paddr == {24'h0, CTRL_ADDR}) begin
            ctrl_r <= pwdata[5:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RESET_INPUT: assert property ($rose(presetn) && alt_en == '0
        |-> &pin_oe_n) else $error("pin driven after reset");
    AST_ADDR_BUS: assert property (xm |-> pin_oe_n[15:0] == 16'h0
        && pin_out[15:0] == external_address_lines)
        else $error("address bus not on address ports");
    AST_CTRL_BUS: assert property (xm |-> ((~pin_oe_n[31:24]
        ^ bus_ctrl_drive) & BUS_CTRL_MASK) == 8'h0 && ((pin_out[31:24]
        ^ bus_ctrl_out) & bus_ctrl_drive & BUS_CTRL_MASK) == 8'h0)
        else $error("bus control bits wrong");
    AST_DATA_BUS: assert property (xm |-> pin_oe_n[23:16]
        == {8{!ext_data_drive}}) else $error("data bus direction wrong");
    AST_FRAME: assert property (ctrl_r[CTRL_SOFE_BIT] |->
        !pin_oe_n[53] && pin_out[53] == frame_pulse)
        else $error("frame pulse not on pin");
    AST_ALT_DIR: assert property (|alt_en[65:58] |-> (alt_en[65:58]
        & (pin_oe_n[65:58] ^ ~alt_dir[65:58])) == 8'h0)
        else $error("second function direction ignored");
    AST_DATA_WR_DIR: assert property (wr && !paddr[2] && paddr < 32'h48
        ##1 $stable(alt_en) && $stable(alt_dir) |-> $stable(pin_oe_n))
        else $error("data write changed a driver");
    AST_LATCH_NEXT: assert property (wr && paddr == 32'h20
        ##1 alt_en[36:32] == 5'h0 |-> (({27'h0, pin_out[36:32]}
        ^ $past(pwdata)) & {27'h0, ~pin_oe_n[36:32]}) == 32'h0)
        else $error("latch not on pin after write");
endmodule
bind ppd_port_top ppd_port_checker ppd_port_checker_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .proc_mode(proc_mode),
    .external_address_lines(external_address_lines),
    .bus_ctrl_out(bus_ctrl_out), .bus_ctrl_drive(bus_ctrl_drive),
    .ext_data_drive(ext_data_drive), .frame_pulse(frame_pulse),
    .alt_en(alt_en), .alt_dir(alt_dir));

// [ppd_pin_load.sv]
// external loads and sources seen by the port pins
`timescale 1ns/1ps
module ppd_pin_load
    import ppd_pkg::*;
(
    input wire logic [ppd_pkg::NPINS-1:0] pin_out,
    input wire logic [ppd_pkg::NPINS-1:0] pin_oe_n,
    input wire logic [ppd_pkg::NPINS-1:0] load_en,
    input wire logic [ppd_pkg::NPINS-1:0] load_val,
    output logic [ppd_pkg::NPINS-1:0] pin_in
);
    // a strong load wins over the driver, so read-back must use the latch
    assign pin_in = (~pin_oe_n & ~load_en & pin_out)
        | ((pin_oe_n | load_en) & load_val);
endmodule

// [tb_ppd_port_top.sv]
// self-checking bench for the port pin direction mux
`timescale 1ns/1ps
module tb_ppd_port_top;
    import ppd_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, xd_drv = 1'b0, md_drv = 1'b0, frame_pulse = 1'b0;
    logic ob_flag = 1'b0, ib_flag = 1'b0, pready, pslverr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, d, m, mk, lv;
    logic [NPINS-1:0] alt_en = '0, alt_dir = '0, alt_out = '0, load_val;
    logic [NPINS-1:0] pin_in, pin_out, pin_oe_n, eo, ed, fm, load_en;
    logic [15:0] addr_lines = 16'h0;
    logic [7:0] bc_out = 8'h0, bc_drv = 8'h0, xd_out = 8'h0, md_out = 8'h0;
    logic [1:0] proc_mode;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int errors = 0, checks = 0;
    always #2.5 pclk = ~pclk;
    ppd_port_top ppd_port_top_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .proc_mode(proc_mode),
        .external_address_lines(addr_lines), .bus_ctrl_out(bc_out),
        .bus_ctrl_drive(bc_drv), .ext_data_out(xd_out),
        .ext_data_drive(xd_drv), .master_data_out(md_out),
        .master_data_drive(md_drv), .output_buffer_full_flag0(ob_flag),
        .input_buffer_full_flag0(ib_flag), .frame_pulse(frame_pulse),
        .alt_en(alt_en), .alt_dir(alt_dir), .alt_out(alt_out));
    ppd_pin_load ppd_pin_load_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .load_en(load_en), .load_val(load_val), .pin_in(pin_in));
    task wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task cmp_rd(input logic [32:0] ex, input logic [32:0] got);
        checks++;
        if (got !== ex) begin
            errors++;
            $display("CHECK FAILED read exp %h got %h", ex, got);
        end
    endtask
    task cmp_pin(input string nm, input logic [NPINS-1:0] ex, got);
        checks++;
        if (got !== ex) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [31:0] dt);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
    endtask
    task rd(input logic [31:0] a, input logic [32:0] ex);
        exp_q.push_back(ex);
        apb(1'b0, a, 32'h0);
    endtask
    // release the bus so the pins are looked at while nothing moves
    task settle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            e = exp_q.pop_front();
            cmp_rd(e, {pslverr, prdata});
        end
    end
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        wrap_up;
    end
    initial begin
        void'($urandom(92));
        load_val <= NPINS'({$urandom, $urandom, $urandom});
        load_en <= NPINS'({$urandom, $urandom, $urandom});
        eo = '0;
        ed = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < NPORTS; k++) rd(32'(k) * 8 + 4, 33'h0);
        for (int k = 0; k < NPORTS; k++) begin
            mk = (32'h1 << PORT_WIDTH[k]) - 32'h1;
            lv = 32'(load_val >> PORT_BASE[k]);
            m = $urandom & mk;
            d = $urandom;
            apb(1'b1, 32'(k) * 8 + 4, m);
            apb(1'b1, 32'(k) * 8, d);
            rd(32'(k) * 8, {1'b0, ((d & m) | (lv & ~m)) & mk});
            eo |= NPINS'(~m & mk) << PORT_BASE[k];
            ed |= NPINS'(d & m) << PORT_BASE[k];
        end
        rd(32'h4c, 33'h100000000);
        rd(32'h1, 33'h100000000);
        settle;
        cmp_pin("dir", eo, pin_oe_n);
        cmp_pin("out", ed, pin_out & ~eo);
        @(posedge pclk);
        for (int md = 1; md < 3; md++) begin
            addr_lines <= 16'($urandom);
            bc_drv <= 8'($urandom);
            bc_out <= 8'($urandom);
            xd_drv <= 1'($urandom);
            xd_out <= 8'($urandom);
            apb(1'b1, 32'h48, 32'(md));
            settle;
            cmp_pin("abus", NPINS'(addr_lines),
                NPINS'(pin_out[15:0]));
            cmp_pin("mode", NPINS'(md), NPINS'(proc_mode));
            cmp_pin("bctl", NPINS'(~bc_drv & BUS_CTRL_MASK),
                NPINS'(pin_oe_n[31:24] & BUS_CTRL_MASK));
            cmp_pin("bctl_out", NPINS'(bc_out & bc_drv & BUS_CTRL_MASK),
                NPINS'(pin_out[31:24] & bc_drv & BUS_CTRL_MASK));
            cmp_pin("dbus", NPINS'({{8{~xd_drv}}, xd_out}),
                NPINS'({pin_oe_n[23:16], pin_out[23:16]}));
            @(posedge pclk);
        end
        frame_pulse <= 1'($urandom);
        ob_flag <= 1'($urandom);
        ib_flag <= 1'($urandom);
        md_drv <= 1'b1;
        md_out <= 8'($urandom);
        apb(1'b1, 32'h48, 32'h3c);
        rd(32'h48, 33'h3c);
        settle;
        fm = (NPINS'(8'hff) << 45) | (NPINS'(3'h3) << 39) | (NPINS'(1) << 53);
        ed = (NPINS'(md_out) << 45) | (NPINS'({ib_flag, ob_flag}) << 39)
            | (NPINS'(frame_pulse) << 53);
        cmp_pin("fn", ed, pin_out & fm);
        cmp_pin("fn_dir", '0, pin_oe_n & fm);
        cmp_pin("strobe", NPINS'(4'hf) << 41,
            pin_oe_n & (NPINS'(4'hf) << 41));
        @(posedge pclk);
        alt_en <= NPINS'(8'hff) << 58;
        alt_dir <= NPINS'($urandom) << 58;
        alt_out <= NPINS'($urandom) << 58;
        apb(1'b1, 32'h48, 32'h0);
        settle;
        cmp_pin("alt", ~alt_dir & alt_en, pin_oe_n & alt_en);
        cmp_pin("alt_out", alt_out & alt_en, pin_out & alt_en);
        // second reset in mid-run: directions must fall back to input
        @(posedge pclk);
        presetn <= 1'b0;
        alt_en <= '0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        cmp_pin("reset", {NPINS{1'b1}}, pin_oe_n);
        @(posedge pclk);
        rd(32'h44, 33'h0);
        settle;
        wrap_up;
    end
endmodule
